// >>> plb_pkg.sv
package plb_pkg;
  localparam int N_IO = 8;
  localparam int N_DED = 6;
  localparam int N_GCLK = 4;
  localparam int N_MC = 16;
  localparam int N_CSM = 33;
  localparam int N_ISM = 24;
  localparam int N_PT = 90;
  localparam int PT_OE_BASE = 80;
  localparam int PT_INIT_A = 88;
  localparam int PT_INIT_B = 89;
  localparam int PT_PER_CL = 5;
  localparam int N_XBLK = 168;
  localparam int N_POOL = 202;
  localparam int DR_LEN = 42;
  // config word index map (byte address is four times the index)
  localparam logic [8:0] W_PT_BASE = 9'h000;
  localparam logic [8:0] W_CSM_BASE = 9'h110;
  localparam logic [8:0] W_ISM_BASE = 9'h132;
  localparam logic [8:0] W_CLKGEN = 9'h14a;
  localparam logic [8:0] W_MC_BASE = 9'h150;
  localparam logic [8:0] W_BLK = 9'h160;
  localparam logic [8:0] W_IOC_BASE = 9'h161;
  localparam logic [8:0] CFG_WORDS = 9'h169;
  localparam logic [8:0] W_ST_PINS = 9'h180;
  localparam logic [8:0] W_ST_MC = 9'h181;
  localparam logic [8:0] W_ST_CLK = 9'h182;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  // macrocell word fields
  localparam int MC_F_OFF = 0;
  localparam int MC_F_KEEP = 2;
  localparam int MC_F_MODE = 3;
  localparam int MC_F_ASYNC = 5;
  localparam int MC_F_CLK = 6;
  localparam int MC_F_PTCLK = 8;
  localparam int MC_F_PTEDGE = 9;
  localparam int MC_F_APRE = 10;
  localparam int MC_F_XORPT = 11;
  localparam int MC_F_POL = 12;
  // io cell and block word fields
  localparam int IOC_F_SEL = 0;
  localparam int IOC_F_LATCH = 3;
  localparam int IOC_F_CLK = 4;
  localparam int BLK_F_SWAP = 0;
  typedef enum logic [1:0] {MODE_COMB = 2'h0, MODE_REG = 2'h1, MODE_LATCH = 2'h2} plb_mode_t;
  localparam logic [3:0] IR_IDCODE = 4'h1;
  localparam logic [3:0] IR_CFG = 4'h2;
  localparam logic [3:0] IR_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPT = 4'h1;
  // arbitrary identity value, bit 0 set as the test standard asks
  localparam logic [31:0] IDCODE_VAL = 32'h0abc_d001;
  typedef enum logic [3:0] {
    T_TLR = 4'h0, T_RTI = 4'h1, T_SDR = 4'h3, T_CDR = 4'h2, T_SHD = 4'h6, T_E1D = 4'h7,
    T_PDR = 4'h5, T_E2D = 4'h4, T_UDR = 4'hc, T_SIR = 4'hd, T_CIR = 4'hf, T_SHI = 4'he,
    T_E1I = 4'ha, T_PIR = 4'hb, T_E2I = 4'h9, T_UIR = 4'h8
  } plb_tap_t;
endpackage

// >>> plb_logic_block.sv
// What this block does
// RQ1 - pins and dedicated inputs feed central matrix
// RQ2 - four clock pins, also usable as inputs
// RQ3 - undriven inputs read high
// RQ4 - central matrix gives 33 signals per block
// RQ5 - input matrix picks 24 of 32
// RQ6 - four block clocks from eight clock forms
// RQ7 - block clocks reach all macrocells, io cells
// RQ8 - 80 logic, 8 enable, 2 init terms
// RQ9 - up to 20 terms sync, 18 async
// RQ10 - lending all five kills logic, four keeps one
// RQ11 - macrocell n reaches clusters n-1 to n+2
// RQ12 - xor gate in allocator path
// RQ13 - macrocell pair k reaches cells k+5..k+8
// RQ14 - io cell j picks macrocells 2j..2j+7
// RQ15 - registered, latched or combinatorial, always fed back
// RQ16 - block clock or term clock either edge
// RQ17 - sync flops init together, swap chooses terms
// RQ18 - async cell init by one term
// RQ19 - each pin enabled by its own term
// RQ20 - input store flop or latch, both reach matrix
// RQ21 - boundary test access port per standard
// RQ22 - serial programming through test port
// RQ23 - configuration held in static storage
`timescale 1ns/1ps
`default_nettype none
module plb_logic_block
  import plb_pkg::*;
(
  input wire logic hclk, // bus and fabric clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  input wire logic [N_DED-1:0] ded_in, // dedicated input pins
  input wire logic [N_GCLK-1:0] gclk_in, // global clock pins
  input wire logic [N_IO-1:0] io_in, // io pin level
  output logic [N_IO-1:0] io_out, // io pin drive value
  output logic [N_IO-1:0] io_oe, // io pin drive enable
  input wire logic [N_XBLK-1:0] xblk_sig, // other blocks' matrix lines
  output logic [N_ISM-1:0] ism_out, // this block's matrix lines
  input wire logic tck, // test clock pin
  input wire logic tms, // test mode select
  input wire logic tdi, // test data in
  output logic tdo, // test data out
  output logic tdo_oe // tdo drive enable
);
  localparam int NS = N_DED + N_GCLK + N_IO + 3;
  logic [NS-1:0] sync1, sync2;
  logic [N_DED-1:0] ded_s;
  logic [N_GCLK-1:0] gclk_s;
  logic [N_IO-1:0] io_s;
  logic tck_s, tms_s, tdi_s, tck_p, tck_rise, tck_fall;
  logic [31:0] cfg [CFG_WORDS];
  logic [N_PT-1:0] pt;
  logic [N_CSM-1:0] csm;
  logic [N_POOL-1:0] pool;
  logic [3:0] bclk, bclk_p, bclk_rise;
  logic [N_MC-1:0] mc_d, mc_q, mc_fb, ck_lvl, ck_p, own_sum, lend_sum, sum;
  logic [N_IO-1:0] io_store, next_io;
  logic [31:0] ism_src;
  logic [N_ISM-1:0] next_ism;
  logic swap, init_pre, init_rst;
  logic ph_wr, ahb_wr, tap_wr;
  logic [8:0] ph_idx, a_idx, tap_idx, tap_ridx;
  logic [31:0] next_rdata, tap_dat, tap_rdata;
  plb_tap_t tap_st, next_tap;
  logic [3:0] ir, irsh;
  logic [DR_LEN-1:0] drsh, next_dr;

  // undriven pins settle high, so the synchroniser starts high too
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1 <= '1; // RQ3
      sync2 <= '1;
      tck_p <= 1'b1;
    end
    else
    begin
      sync1 <= {tdi, tms, tck, io_in, gclk_in, ded_in};
      sync2 <= sync1;
      tck_p <= tck_s;
    end
  end
  assign {tdi_s, tms_s, tck_s, io_s, gclk_s, ded_s} = sync2;
  assign tck_rise = tck_s & ~tck_p;
  assign tck_fall = ~tck_s & tck_p;

  // configuration store; bus write wins a collision with a test-port write
  assign ahb_wr = ph_wr && (ph_idx < CFG_WORDS);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < int'(CFG_WORDS); i++)
        cfg[i] <= CFG_RST;
    end
    else if (ahb_wr)
      cfg[ph_idx] <= hwdata; // RQ23
    else if (tap_wr)
      cfg[tap_idx] <= tap_dat; // RQ22
  end

  // ahb-lite slave, zero wait states
  assign a_idx = haddr[10:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (a_idx < CFG_WORDS)
      next_rdata = (ph_wr && ph_idx == a_idx) ? hwdata : cfg[a_idx];
    else if (a_idx == W_ST_PINS)
      next_rdata = {14'h0000, io_s, gclk_s, ded_s};
    else if (a_idx == W_ST_MC)
      next_rdata = {16'h0000, mc_fb};
    else if (a_idx == W_ST_CLK)
      next_rdata = {20'h0_0000, io_oe, bclk};
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_wr <= 1'b0;
      ph_idx <= 9'h000;
      hrdata <= 32'h0000_0000;
    end
    else if (hsel && hready && htrans[1])
    begin
      ph_wr <= hwrite;
      ph_idx <= a_idx;
      if (!hwrite)
        hrdata <= next_rdata;
    end
    else
      ph_wr <= 1'b0;
  end

  assign pool = {xblk_sig, ism_out, gclk_s, ded_s}; // RQ1 RQ2
  genvar g;
  generate
    for (g = 0; g < N_CSM; g++)
    begin : g_csm
      logic [7:0] sel;
      assign sel = cfg[W_CSM_BASE + 9'(g)][7:0];
      assign csm[g] = (int'(sel) < N_POOL) ? pool[sel] : 1'b0; // RQ4
    end
    // a term with no literal programmed stays low instead of floating high
    for (g = 0; g < N_PT; g++)
    begin : g_pt
      logic [65:0] mask, lit;
      assign mask = {cfg[W_PT_BASE + 9'(3*g+2)][1:0], cfg[W_PT_BASE + 9'(3*g+1)],
                     cfg[W_PT_BASE + 9'(3*g)]};
      for (genvar b = 0; b < N_CSM; b++)
      begin : g_lit
        assign lit[2*b] = csm[b];
        assign lit[2*b+1] = ~csm[b];
      end
      assign pt[g] = (|mask) & (&(~mask | lit)); // RQ8
    end
    for (g = 0; g < 4; g++)
    begin : g_clk
      logic [2:0] cs;
      assign cs = cfg[W_CLKGEN][3*g +: 3];
      assign bclk[g] = gclk_s[cs[1:0]] ^ cs[2]; // RQ6
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn)
  begin
    // syncs reset high and cleared clock words pick pin 0 true, so idle is high
    if (!hresetn)
      bclk_p <= 4'hf;
    else
      bclk_p <= bclk;
  end
  assign bclk_rise = bclk & ~bclk_p;

  assign swap = cfg[W_BLK][BLK_F_SWAP];
  assign init_pre = swap ? pt[PT_INIT_B] : pt[PT_INIT_A]; // RQ17
  assign init_rst = swap ? pt[PT_INIT_A] : pt[PT_INIT_B];

  generate
    for (g = 0; g < N_MC; g++)
    begin : g_mc
      logic [31:0] w;
      logic [4:0] t, own_m, lend_m;
      logic lent, asyn;
      plb_mode_t mode;
      int tgt;
      assign w = cfg[W_MC_BASE + 9'(g)];
      assign t = pt[PT_PER_CL*g +: PT_PER_CL];
      assign mode = plb_mode_t'(w[MC_F_MODE +: 2]);
      assign asyn = w[MC_F_ASYNC];
      // cluster g goes to macrocell g-2+offset; offset 2 keeps it home
      assign tgt = g - 2 + int'(w[MC_F_OFF +: 2]);
      assign lent = (tgt != g);
      // async cells spend terms 3 and 4 on their own clock and init
      always_comb
      begin
        own_m = lent ? (w[MC_F_KEEP] ? 5'h01 : 5'h00) : 5'h1f; // RQ10
        lend_m = lent ? (w[MC_F_KEEP] ? 5'h1e : 5'h1f) : 5'h00;
        if (asyn)
        begin
          own_m = own_m & 5'h07; // RQ9
          lend_m = lend_m & 5'h07;
        end
        if (w[MC_F_XORPT])
          own_m[0] = 1'b0;
      end
      assign own_sum[g] = |(t & own_m);
      always_comb
      begin
        lend_sum[g] = 1'b0;
        for (int d = -1; d <= 2; d++)
        begin
          if (g + d >= 0 && g + d < N_MC && d != 0)
            if (g_mc_tgt(g + d) == g)
              lend_sum[g] = lend_sum[g] | |(pt[PT_PER_CL*(g+d) +: PT_PER_CL] &
                            lend_mask(g + d)); // RQ11
        end
      end
      assign sum[g] = own_sum[g] | lend_sum[g];
      assign mc_d[g] = sum[g] ^ (w[MC_F_XORPT] ? t[0] : w[MC_F_POL]); // RQ12
      assign ck_lvl[g] = (asyn && w[MC_F_PTCLK]) ? (t[3] ^ w[MC_F_PTEDGE])
                         : bclk[w[MC_F_CLK +: 2]]; // RQ16 RQ7
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          mc_q[g] <= 1'b0;
          ck_p[g] <= 1'b1;
        end
        else
        begin
          ck_p[g] <= ck_lvl[g];
          if (asyn && t[4])
            mc_q[g] <= w[MC_F_APRE]; // RQ18
          else if (!asyn && init_rst)
            mc_q[g] <= 1'b0; // RQ17
          else if (!asyn && init_pre)
            mc_q[g] <= 1'b1;
          else if (mode == MODE_REG && ck_lvl[g] && !ck_p[g])
            mc_q[g] <= mc_d[g];
          else if (mode == MODE_LATCH && ck_lvl[g])
            mc_q[g] <= mc_d[g];
        end
      end
      assign mc_fb[g] = (mode == MODE_COMB) ? mc_d[g] : mc_q[g]; // RQ15
    end
  endgenerate

  function automatic int g_mc_tgt(input int c);
    return c - 2 + int'(cfg[W_MC_BASE + 9'(c)][MC_F_OFF +: 2]);
  endfunction
  function automatic logic [4:0] lend_mask(input int c);
    logic [31:0] w;
    w = cfg[W_MC_BASE + 9'(c)];
    return (w[MC_F_KEEP] ? 5'h1e : 5'h1f) & (w[MC_F_ASYNC] ? 5'h07 : 5'h1f);
  endfunction

  generate
    for (g = 0; g < N_IO; g++)
    begin : g_io
      logic [31:0] w;
      logic [3:0] m;
      logic ck;
      assign w = cfg[W_IOC_BASE + 9'(g)];
      assign m = 4'(2*g) + {1'b0, w[IOC_F_SEL +: 3]}; // RQ14 RQ13
      assign next_io[g] = mc_fb[m];
      assign ck = bclk[w[IOC_F_CLK +: 2]]; // RQ7
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          io_store[g] <= 1'b1;
        else if (w[IOC_F_LATCH] ? ck : bclk_rise[w[IOC_F_CLK +: 2]])
          io_store[g] <= io_s[g]; // RQ20
      end
    end
    for (g = 0; g < N_ISM; g++)
    begin : g_ism
      assign next_ism[g] = ism_src[cfg[W_ISM_BASE + 9'(g)][4:0]]; // RQ5
    end
  endgenerate
  assign ism_src = {io_s, io_store, mc_fb}; // RQ20

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      io_out <= 8'h00;
      io_oe <= 8'h00;
      ism_out <= 24'h00_0000;
    end
    else
    begin
      io_out <= next_io;
      io_oe <= pt[PT_OE_BASE +: N_IO]; // RQ19
      ism_out <= next_ism;
    end
  end

  // test access port, sampled on synchronised tck edges
  always_comb
  begin
    unique case (tap_st)
      T_TLR: next_tap = tms_s ? T_TLR : T_RTI;
      T_RTI: next_tap = tms_s ? T_SDR : T_RTI;
      T_SDR: next_tap = tms_s ? T_SIR : T_CDR;
      T_CDR: next_tap = tms_s ? T_E1D : T_SHD;
      T_SHD: next_tap = tms_s ? T_E1D : T_SHD;
      T_E1D: next_tap = tms_s ? T_UDR : T_PDR;
      T_PDR: next_tap = tms_s ? T_E2D : T_PDR;
      T_E2D: next_tap = tms_s ? T_UDR : T_SHD;
      T_UDR: next_tap = tms_s ? T_SDR : T_RTI;
      T_SIR: next_tap = tms_s ? T_TLR : T_CIR;
      T_CIR: next_tap = tms_s ? T_E1I : T_SHI;
      T_SHI: next_tap = tms_s ? T_E1I : T_SHI;
      T_E1I: next_tap = tms_s ? T_UIR : T_PIR;
      T_PIR: next_tap = tms_s ? T_E2I : T_PIR;
      T_E2I: next_tap = tms_s ? T_UIR : T_SHI;
      T_UIR: next_tap = tms_s ? T_SDR : T_RTI;
    endcase
  end
  assign tap_rdata = (tap_ridx < CFG_WORDS) ? cfg[tap_ridx] : 32'h0000_0000;
  always_comb
  begin
    next_dr = {1'b0, drsh[DR_LEN-1:1]};
    if (ir == IR_CFG)
      next_dr[DR_LEN-1] = tdi_s;
    else if (ir == IR_IDCODE)
      next_dr[31] = tdi_s;
    else
      next_dr[0] = tdi_s;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tap_st <= T_TLR;
      ir <= IR_IDCODE;
      irsh <= 4'h0;
      drsh <= '0;
      tap_wr <= 1'b0;
      tap_idx <= 9'h000;
      tap_ridx <= 9'h000;
      tap_dat <= 32'h0000_0000;
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else
    begin
      tap_wr <= 1'b0;
      if (tck_fall)
      begin
        tdo_oe <= (tap_st == T_SHD) || (tap_st == T_SHI);
        tdo <= (tap_st == T_SHI) ? irsh[0] : drsh[0];
      end
      if (tck_rise)
      begin
        tap_st <= next_tap; // RQ21
        unique case (tap_st)
          T_TLR: ir <= IR_IDCODE;
          T_CIR: irsh <= IR_CAPT;
          T_SHI: irsh <= {tdi_s, irsh[3:1]};
          T_UIR: ir <= irsh;
          T_CDR: drsh <= (ir == IR_CFG) ? {1'b0, tap_ridx, tap_rdata}
                         : (ir == IR_IDCODE) ? {10'h000, IDCODE_VAL} : '0;
          T_SHD: drsh <= next_dr;
          T_UDR:
            if (ir == IR_CFG)
            begin
              tap_ridx <= drsh[40:32];
              tap_idx <= drsh[40:32];
              tap_dat <= drsh[31:0];
              tap_wr <= drsh[41] && (drsh[40:32] < CFG_WORDS); // RQ22
            end
          default: ;
        endcase
      end
    end
  end

  property p_pullup;
    @(posedge hclk) disable iff (!hresetn) (io_in == 8'hff) [*2] |=> (io_s == 8'hff);
  endproperty
  a_pullup: assert property (p_pullup) else $error("io pins not seen high"); // RQ3
  property p_oe;
    @(posedge hclk) disable iff (!hresetn) ##1 io_oe == $past(pt[PT_OE_BASE +: N_IO]);
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable not from its term"); // RQ19
  property p_route0;
    @(posedge hclk) disable iff (!hresetn)
      ##1 io_out[0] == $past(mc_fb[cfg[W_IOC_BASE][2:0]]);
  endproperty
  a_route0: assert property (p_route0) else $error("io cell 0 wrong macrocell"); // RQ14
  property p_lend_all;
    @(posedge hclk) disable iff (!hresetn) (g_mc[3].lent && !g_mc[3].w[MC_F_KEEP]) |->
      !own_sum[3];
  endproperty
  a_lend_all: assert property (p_lend_all) else $error("lending cell kept logic"); // RQ10
  property p_sync_rst;
    @(posedge hclk) disable iff (!hresetn) (!g_mc[0].asyn && init_rst) |=> !mc_q[0];
  endproperty
  a_sync_rst: assert property (p_sync_rst) else $error("block reset missed"); // RQ17
  property p_async_init;
    @(posedge hclk) disable iff (!hresetn) (g_mc[1].asyn && g_mc[1].t[4]) |=>
      mc_q[1] == $past(g_mc[1].w[MC_F_APRE]);
  endproperty
  a_async_init: assert property (p_async_init) else $error("cell init wrong"); // RQ18
  property p_in_ff;
    @(posedge hclk) disable iff (!hresetn)
      (!g_io[0].w[IOC_F_LATCH] && bclk_rise[g_io[0].w[IOC_F_CLK +: 2]]) |=>
      io_store[0] == $past(io_s[0]);
  endproperty
  a_in_ff: assert property (p_in_ff) else $error("input store missed edge"); // RQ20
  property p_tap_wr;
    @(posedge hclk) disable iff (!hresetn) (tap_wr && !ahb_wr) |=>
      cfg[$past(tap_idx)] == $past(tap_dat);
  endproperty
  a_tap_wr: assert property (p_tap_wr) else $error("test port write lost"); // RQ22
  property p_tap_rst;
    @(posedge hclk) disable iff (!hresetn) (tck_rise && tms_s && tap_st == T_SIR) |=>
      tap_st == T_TLR;
  endproperty
  a_tap_rst: assert property (p_tap_rst) else $error("tap not reset"); // RQ21
  property p_tap_ir;
    @(posedge hclk) disable iff (!hresetn) (tck_rise && tap_st == T_TLR) |=> ir == IR_IDCODE;
  endproperty
  a_tap_ir: assert property (p_tap_ir) else $error("ir not back to identity"); // RQ21
  property p_reg_clk;
    @(posedge hclk) disable iff (!hresetn)
      (g_mc[0].mode == MODE_REG && ck_lvl[0] && !ck_p[0] && !init_rst && !init_pre &&
       !(g_mc[0].asyn && g_mc[0].t[4])) |=> mc_q[0] == $past(mc_d[0]);
  endproperty
  a_reg_clk: assert property (p_reg_clk) else $error("macrocell missed edge"); // RQ16
  c_reg: cover property (@(posedge hclk) disable iff (!hresetn) $rose(mc_q[0]));
  c_oe: cover property (@(posedge hclk) disable iff (!hresetn) io_oe != 8'h00);
  c_tap: cover property (@(posedge hclk) disable iff (!hresetn) tap_wr);
endmodule // plb_logic_block
`default_nettype wire

// >>> plb_board.sv
`timescale 1ns/1ps
`default_nettype none
module plb_board
  import plb_pkg::*;
(
  input wire logic hclk, // fabric clock
  input wire logic [N_IO-1:0] io_out, // device pin value
  input wire logic [N_IO-1:0] io_oe, // device pin enable
  input wire logic [N_IO-1:0] ext_en, // board drives pin
  input wire logic [N_IO-1:0] ext_val, // board pin value
  output logic [N_IO-1:0] io_in, // resolved pin level
  input wire logic tdo, // test data out
  input wire logic tdo_oe, // tdo enable
  output logic tck, // test clock
  output logic tms, // test mode select
  output logic tdi // test data in
);
  // a pin nobody drives floats up to the pull-up level
  assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_val) | (~io_oe & ~ext_en);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // halves of six cycles keep clear of the device's input sync delay
  task automatic step(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    tck <= 1'b0;
    repeat (6) @(posedge hclk);
    q = tdo_oe ? tdo : 1'b1;
    tck <= 1'b1;
    repeat (6) @(posedge hclk);
  endtask
  task automatic tap_reset();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
  // from idle: select, capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [41:0] din,
                      output logic [41:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask
endmodule // plb_board
`default_nettype wire

// >>> plb_logic_block_bench.sv
`timescale 1ns/1ps
`default_nettype none
module plb_logic_block_bench
  import plb_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [N_DED-1:0] ded = '0;
  logic [N_GCLK-1:0] gclk = '0;
  logic [N_IO-1:0] io_in, io_out, io_oe;
  logic [N_IO-1:0] ext_en = '0;
  logic [N_IO-1:0] ext_val = '0;
  logic [N_ISM-1:0] ism;
  logic tck, tms, tdi, tdo, tdo_oe;
  logic [31:0] rd;
  logic [41:0] q;
  int failures = 0;
  int samples_checked = 0;
  always #12.5 hclk = ~hclk;
  plb_logic_block i_plb_logic_block (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ded_in(ded), .gclk_in(gclk),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .xblk_sig('0), .ism_out(ism), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
  plb_board i_plb_board (.hclk(hclk), .io_out(io_out), .io_oe(io_oe), .ext_en(ext_en),
    .ext_val(ext_val), .io_in(io_in), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi));
  task automatic complete_run();
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [41:0] exp, input logic [41:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  // one single-word transfer; the bound only guards against a dead bus
  task automatic bus(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {21'h0, idx, 2'b00};
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (hreadyout !== 1'b1)
    begin
      failures++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [8:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rdw(input logic [8:0] idx);
    bus(1'b0, idx, 32'h0000_0000);
  endtask
  // pin round trip: sync, output register, pin resync, matrix register
  task automatic settle(input logic [5:0] d, input logic [3:0] g);
    ded <= d;
    gclk <= g;
    repeat (7) @(posedge hclk);
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    i_plb_board.tap_reset();
    rdw(W_MC_BASE);
    chk("mc0 reset", CFG_RST, rd);
    wr(9'h170, 32'hffff_ffff);
    rdw(9'h170);
    chk("unmapped", 32'h0000_0000, rd);
    chk("hresp", 1'b0, hresp);
    wr(W_CSM_BASE + 9'h1, 32'h0000_0001);
    wr(W_CSM_BASE + 9'h2, 32'h0000_0002);
    rdw(W_CSM_BASE + 9'h2);
    chk("csm2", 32'h0000_0002, rd);
    wr(W_CLKGEN, 32'h0000_0020);
    wr(W_MC_BASE, 32'h0000_000a);
    wr(W_PT_BASE, 32'h0000_0001);
    wr(9'h108, 32'h0000_0010);
    settle(6'h04, 4'h0);
    rdw(W_ST_MC);
    chk("init preset", 1'b1, rd[0]);
    wr(W_BLK, 32'h0000_0001);
    repeat (4) @(posedge hclk);
    rdw(W_ST_MC);
    chk("init swapped", 1'b0, rd[0]);
    settle(6'h01, 4'h0);
    rdw(W_ST_CLK);
    chk("bclk low", 4'h2, rd[3:0]);
    rdw(W_ST_MC);
    chk("no edge yet", 1'b0, rd[0]);
    settle(6'h01, 4'h1);
    rdw(W_ST_CLK);
    chk("bclk high", 4'hd, rd[3:0]);
    rdw(W_ST_MC);
    chk("clocked", 1'b1, rd[0]);
    settle(6'h00, 4'h1);
    rdw(W_ST_MC);
    chk("held", 1'b1, rd[0]);
    // macrocell 1 async, registered, init term 9 from ded2 acts as preset
    wr(W_MC_BASE + 9'h1, 32'h0000_042a);
    wr(9'h01b, 32'h0000_0010);
    settle(6'h04, 4'h1);
    rdw(W_ST_MC);
    chk("async preset", 1'b1, rd[1]);
    // comb macrocell 0 to pins 0 and 7, enables both from ded1
    wr(W_MC_BASE, 32'h0000_0002);
    wr(9'h0f0, 32'h0000_0004);
    wr(W_IOC_BASE + 9'h7, 32'h0000_0002);
    wr(9'h105, 32'h0000_0004);
    wr(W_ISM_BASE + 9'h1, 32'h0000_0018);
    wr(W_ISM_BASE + 9'h2, 32'h0000_0010);
    settle(6'h03, 4'h1);
    chk("oe on", 8'h81, io_oe);
    chk("out high", 8'h81, io_out);
    chk("ism high", 2'b11, ism[1:0]);
    settle(6'h02, 4'h1);
    chk("out low", 8'h00, io_out);
    chk("ism low", 2'b00, ism[1:0]);
    rdw(W_ST_PINS);
    chk("pins", {8'h7e, 4'h1, 6'h02}, rd[17:0]);
    ext_en <= 8'h01;
    settle(6'h00, 4'h1);
    chk("oe off", 8'h00, io_oe);
    chk("store old", 2'b10, ism[2:1]);
    settle(6'h00, 4'h0);
    settle(6'h00, 4'h1);
    chk("store new", 2'b00, ism[2:1]);
    ext_en <= 8'h00;
    i_plb_board.scan(1'b0, 32, 42'h0, q);
    chk("idcode", IDCODE_VAL, q[31:0]);
    i_plb_board.scan(1'b1, 4, {38'h0, IR_CFG}, q);
    chk("ir capture", IR_CAPT, q[3:0]);
    i_plb_board.scan(1'b0, 42, {1'b1, W_CSM_BASE + 9'h14, 32'h0000_00c9}, q);
    rdw(W_CSM_BASE + 9'h14);
    chk("tap write", 32'h0000_00c9, rd);
    i_plb_board.scan(1'b0, 42, {1'b0, W_CSM_BASE + 9'h14, 32'h0000_0000}, q);
    chk("tap read", {1'b0, W_CSM_BASE + 9'h14, 32'h0000_00c9}, q);
    i_plb_board.tap_reset();
    i_plb_board.scan(1'b0, 32, 42'h0, q);
    chk("idcode after reset", IDCODE_VAL, q[31:0]);
    complete_run();
  end
endmodule // plb_logic_block_bench
`default_nettype wire
